// ### verilog/vic_pkg.sv
// constants and types shared by the vectored interrupt controller
`default_nettype none
package vic_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses are four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] req_one_idx    = 12'h03c;
    localparam logic [11:0] req_two_idx    = 12'h03d;
    localparam logic [11:0] enable_one_idx = 12'h03e;
    localparam logic [11:0] enable_two_idx = 12'h03f;
    localparam logic [11:0] edge_sel_idx   = 12'h040;
    localparam logic [11:0] key_dir_idx    = 12'h041;
    localparam logic [11:0] status_idx     = 12'h042;
    localparam logic [7:0]  reset_value    = 8'h00;

    // ------------------------------------------------------------
    // source bit positions in the 16-bit request word
    // ------------------------------------------------------------
    localparam int src_bus_reset = 0;
    localparam int src_sof       = 1;
    localparam int src_usb_dev   = 2;
    localparam int src_ext_bus   = 3;
    localparam int src_pin_a     = 4;
    localparam int src_timer_x   = 5;
    localparam int src_timer_1   = 6;
    localparam int src_timer_2   = 7;
    localparam int src_pin_b     = 8;
    localparam int src_hub       = 9;
    localparam int src_ser_rx    = 10;
    localparam int src_ser_tx    = 11;
    localparam int src_counter   = 12;
    localparam int src_key       = 13;
    localparam int src_adc       = 14;
    localparam int num_maskable  = 15;

    // ------------------------------------------------------------
    // vectors: low byte address of each pair, two bytes apart
    // ------------------------------------------------------------
    localparam logic [15:0] reset_vector_lo = 16'hfffc;
    localparam logic [15:0] break_vector_lo = 16'hffdc;
    localparam logic [4:0]  break_code      = 5'h10;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int  clk_mhz         = 250;
    localparam real se0_time_us     = 2.5;
    localparam int  se0_cycles      = int'(se0_time_us * clk_mhz);
    localparam int  idle_time_ms    = 3;
    localparam int  idle_cycles     = idle_time_ms * 1000 * clk_mhz;

    // ------------------------------------------------------------
    // accept sequence
    // ------------------------------------------------------------
    typedef enum logic [4:0]
    {
        st_idle    = 5'h01,
        st_push_hi = 5'h02,
        st_push_lo = 5'h04,
        st_push_ps = 5'h08,
        st_fetch   = 5'h10
    } acc_state_type;

endpackage
`default_nettype wire

// ### verilog/vectored_interrupt_controller.sv
// vectored interrupt controller with source conditioning and apb registers
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller
#(
    parameter int key_width   = 8,
    parameter int se0_count   = vic_pkg::se0_cycles,
    parameter int idle_count  = vic_pkg::idle_cycles
)
(
    input  wire logic                 pclk,             // system clock
    input  wire logic                 presetn,          // async reset, low
    input  wire logic                 psel,             // apb select
    input  wire logic                 penable,          // apb access phase
    input  wire logic                 pwrite,           // apb direction
    input  wire logic [11:0]          paddr,            // apb byte address
    input  wire logic [31:0]          pwdata,           // apb write data
    output logic                      pready,           // apb ready
    output logic [31:0]               prdata,           // apb read data
    output logic                      pslverr,          // apb error
    input  wire logic                 usb_se0,          // bus in single-ended zero
    input  wire logic                 usb_idle,         // bus idle (j state)
    input  wire logic                 usb_resume,       // k state or se0 seen in suspend
    input  wire logic                 usb_sof,          // sof detected pulse
    input  wire logic                 usb_xact_done,    // transaction complete pulse
    input  wire logic                 ext_bus_done,     // rx, tx or dma complete pulse
    input  wire logic                 ext_pin_irq_a,    // external pin a level
    input  wire logic                 ext_pin_irq_b,    // external pin b level
    input  wire logic                 counter_pin,      // counter pin level
    input  wire logic                 timer_x_uflow,    // timer x underflow pulse
    input  wire logic                 timer_1_uflow,    // timer 1 underflow pulse
    input  wire logic                 timer_2_uflow,    // timer 2 underflow pulse
    input  wire logic                 hub_port_change,  // hub port change pulse
    input  wire logic                 ser_rx_done,      // serial receive done pulse
    input  wire logic                 ser_tx_done,      // serial transmit done pulse
    input  wire logic                 adc_done,         // conversion done pulse
    input  wire logic [key_width-1:0] key_port,         // key port pin levels
    input  wire logic                 soft_break_instruction, // break executed pulse
    input  wire logic                 cpu_ready,        // core can take an interrupt
    input  wire logic [15:0]          cpu_pc,           // core program counter
    input  wire logic [7:0]           cpu_ps,           // core status register
    input  wire logic                 cpu_set_flag,     // core sets disable flag
    input  wire logic                 cpu_clr_flag,     // core clears disable flag
    output logic                      stack_push,       // push strobe
    output logic [7:0]                stack_data,       // byte to push
    output logic                      vector_load,      // pc load strobe
    output logic [15:0]               vector_addr,      // low byte address of vector
    output logic                      irq_flag,         // global disable flag
    output logic                      accept_busy       // accept sequence running
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0]          req_q;
    logic [15:0]          enable_q;
    logic [2:0]           edge_sel_q;
    logic [key_width-1:0] key_dir_q;
    logic                 flag_q;
    logic                 reset_pend_q;
    logic                 brk_pend_q;
    logic [2:0]           pin_prev_q;
    logic                 key_and_prev_q;
    logic [31:0]          se0_cnt_q;
    logic [31:0]          idle_cnt_q;
    logic                 se0_hit_q;
    logic                 idle_hit_q;
    logic [4:0]           code_q;
    logic [15:0]          pc_q;
    logic [7:0]           ps_q;
    vic_pkg::acc_state_type state_q;
    vic_pkg::acc_state_type state_d;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic [11:0] widx    = {2'h0, paddr[11:2]};
    wire logic        wr_cyc  = psel & penable & pwrite;
    wire logic        rd_cyc  = psel & penable & ~pwrite;
    wire logic        hit_r1  = widx == vic_pkg::req_one_idx;
    wire logic        hit_r2  = widx == vic_pkg::req_two_idx;
    wire logic        hit_e1  = widx == vic_pkg::enable_one_idx;
    wire logic        hit_e2  = widx == vic_pkg::enable_two_idx;
    wire logic        hit_es  = widx == vic_pkg::edge_sel_idx;
    wire logic        hit_kd  = widx == vic_pkg::key_dir_idx;
    wire logic        hit_st  = widx == vic_pkg::status_idx;
    wire logic        mapped  = hit_r1 | hit_r2 | hit_e1 | hit_e2 | hit_es | hit_kd | hit_st;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // writing 0 clears a request, writing 1 leaves it alone
    wire logic [15:0] sw_clr = {wr_cyc & hit_r2 ? ~pwdata[7:0] : 8'h00,
                                wr_cyc & hit_r1 ? ~pwdata[7:0] : 8'h00};

    // ------------------------------------------------------------
    // source conditioning
    // ------------------------------------------------------------
    wire logic [2:0] pin_now  = {counter_pin, ext_pin_irq_b, ext_pin_irq_a};
    // edge select bit 0 is rising, 1 is falling
    wire logic [2:0] pin_edge = (pin_now & ~pin_prev_q & ~edge_sel_q)
                              | (~pin_now & pin_prev_q & edge_sel_q);
    // output-mode pins read as 1 so they never pull the and low
    wire logic key_and   = &(key_port | key_dir_q);
    wire logic key_fall  = key_and_prev_q & ~key_and;
    wire logic se0_fire  = usb_se0 & (se0_cnt_q == 32'(se0_count - 1)) & ~se0_hit_q;
    wire logic idle_fire = usb_idle & (idle_cnt_q == 32'(idle_count - 1)) & ~idle_hit_q;

    wire logic [15:0] hw_set;
    assign hw_set[vic_pkg::src_bus_reset] = se0_fire;
    assign hw_set[vic_pkg::src_sof]       = usb_sof;
    assign hw_set[vic_pkg::src_usb_dev]   = usb_resume | idle_fire | usb_xact_done;
    assign hw_set[vic_pkg::src_ext_bus]   = ext_bus_done;
    assign hw_set[vic_pkg::src_pin_a]     = pin_edge[0];
    assign hw_set[vic_pkg::src_timer_x]   = timer_x_uflow;
    assign hw_set[vic_pkg::src_timer_1]   = timer_1_uflow;
    assign hw_set[vic_pkg::src_timer_2]   = timer_2_uflow;
    assign hw_set[vic_pkg::src_pin_b]     = pin_edge[1];
    assign hw_set[vic_pkg::src_hub]       = hub_port_change;
    assign hw_set[vic_pkg::src_ser_rx]    = ser_rx_done;
    assign hw_set[vic_pkg::src_ser_tx]    = ser_tx_done;
    assign hw_set[vic_pkg::src_counter]   = pin_edge[2];
    assign hw_set[vic_pkg::src_key]       = key_fall;
    assign hw_set[vic_pkg::src_adc]       = adc_done;
    assign hw_set[15]                     = 1'b0;

    // ------------------------------------------------------------
    // priority selection
    // ------------------------------------------------------------
    wire logic [14:0] eligible = req_q[14:0] & enable_q[14:0] & {15{~flag_q}};
    logic [4:0] win_code;
    logic       win_any;
    logic [14:0] win_onehot;

    // lowest index wins; code 0..14 maps to priority 2..16
    always_comb
    begin
        win_code   = vic_pkg::break_code;
        win_any    = brk_pend_q;
        win_onehot = 15'h0000;
        for (int i = vic_pkg::num_maskable - 1; i >= 0; i--)
        begin
            if (eligible[i])
            begin
                win_code   = 5'(i);
                win_any    = 1'b1;
                win_onehot = 15'(1) << i;
            end
        end
    end

    wire logic start_irq   = (state_q == vic_pkg::st_idle) & cpu_ready & win_any & ~reset_pend_q;
    wire logic start_reset = (state_q == vic_pkg::st_idle) & reset_pend_q;
    wire logic [15:0] acc_clr = start_irq ? {1'b0, win_onehot} : 16'h0000;

    // ------------------------------------------------------------
    // accept sequence
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            vic_pkg::st_idle:
            begin
                if (start_reset)
                    state_d = vic_pkg::st_fetch;
                else if (start_irq)
                    state_d = vic_pkg::st_push_hi;
            end
            vic_pkg::st_push_hi: state_d = vic_pkg::st_push_lo;
            vic_pkg::st_push_lo: state_d = vic_pkg::st_push_ps;
            vic_pkg::st_push_ps: state_d = vic_pkg::st_fetch;
            vic_pkg::st_fetch:   state_d = vic_pkg::st_idle;
        endcase
    end

    assign accept_busy = state_q != vic_pkg::st_idle;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q      <= vic_pkg::st_idle;
            code_q       <= 5'h00;
            pc_q         <= 16'h0000;
            ps_q         <= 8'h00;
            reset_pend_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            if (start_reset)
            begin
                reset_pend_q <= 1'b0;
                code_q       <= 5'h1f;
            end
            else if (start_irq)
            begin
                code_q <= win_code;
                pc_q   <= cpu_pc;
                ps_q   <= cpu_ps;
            end
        end
    end

    // reset uses code 1f, which the vector mux maps to the top pair ahead of this formula
    wire logic [15:0] vec_lo = vic_pkg::reset_vector_lo - 16'(({11'h000, code_q} + 16'h0001) << 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stack_push  <= 1'b0;
            stack_data  <= 8'h00;
            vector_load <= 1'b0;
            vector_addr <= vic_pkg::reset_vector_lo;
        end
        else
        begin
            stack_push  <= state_d == vic_pkg::st_push_hi
                         | state_d == vic_pkg::st_push_lo
                         | state_d == vic_pkg::st_push_ps;
            stack_data  <= state_d == vic_pkg::st_push_hi ? cpu_pc[15:8]
                         : state_d == vic_pkg::st_push_lo ? pc_q[7:0] : ps_q;
            vector_load <= state_q == vic_pkg::st_fetch;
            // break sits one pair below the last maskable source, off the code formula
            vector_addr <= (code_q == 5'h1f) ? vic_pkg::reset_vector_lo
                         : (code_q == vic_pkg::break_code) ? vic_pkg::break_vector_lo
                         : vec_lo;
        end
    end

    // ------------------------------------------------------------
    // request, enable and flag state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_q      <= 16'h0000;
            brk_pend_q <= 1'b0;
            flag_q     <= 1'b1;
        end
        else
        begin
            req_q <= hw_set | (req_q & ~sw_clr & ~acc_clr);
            brk_pend_q <= soft_break_instruction | (brk_pend_q & ~(start_irq & ~|eligible));
            if (start_irq | start_reset)
                flag_q <= 1'b1;
            else if (cpu_set_flag)
                flag_q <= 1'b1;
            else if (cpu_clr_flag)
                flag_q <= 1'b0;
        end
    end

    assign irq_flag = flag_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q   <= 16'h0000;
            edge_sel_q <= 3'h0;
            key_dir_q  <= '0;
        end
        else if (wr_cyc)
        begin
            if (hit_e1)
                enable_q[7:0] <= pwdata[7:0];
            if (hit_e2)
                enable_q[15:8] <= {1'b0, pwdata[6:0]};
            if (hit_es)
                edge_sel_q <= pwdata[2:0];
            if (hit_kd)
                key_dir_q <= pwdata[key_width-1:0];
        end
    end

    // edge history is inverted for each pin whose select changes, so a select change
    // can fire one request; software follows the disable-wait-clear sequence
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_prev_q     <= 3'h0;
            key_and_prev_q <= 1'b1;
            se0_cnt_q      <= 32'h0;
            idle_cnt_q     <= 32'h0;
            se0_hit_q      <= 1'b0;
            idle_hit_q     <= 1'b0;
        end
        else
        begin
            pin_prev_q     <= pin_now ^ (wr_cyc & hit_es ? (pwdata[2:0] ^ edge_sel_q) : 3'h0);
            key_and_prev_q <= key_and;
            se0_cnt_q      <= usb_se0 & ~se0_hit_q ? se0_cnt_q + 32'h1 : 32'h0;
            se0_hit_q      <= usb_se0 & (se0_hit_q | se0_fire);
            idle_cnt_q     <= usb_idle & ~idle_hit_q ? idle_cnt_q + 32'h1 : 32'h0;
            idle_hit_q     <= usb_idle & (idle_hit_q | idle_fire);
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire logic [7:0] rd_byte = hit_r1 ? req_q[7:0]
                             : hit_r2 ? req_q[15:8]
                             : hit_e1 ? enable_q[7:0]
                             : hit_e2 ? enable_q[15:8]
                             : hit_es ? {5'h00, edge_sel_q}
                             : hit_kd ? 8'(key_dir_q)
                             : hit_st ? {2'h0, accept_busy, code_q} : vic_pkg::reset_value;

    assign prdata = rd_cyc ? {24'h000000, rd_byte} : 32'h00000000;

endmodule
`default_nettype wire

// ### dv/vic_props.sv
// assertion checker for the vectored interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
module vic_props
#(
    parameter int key_width  = 8,
    parameter int se0_count  = vic_pkg::se0_cycles,
    parameter int idle_count = vic_pkg::idle_cycles
)
(
    input wire logic        pclk,        // system clock
    input wire logic        presetn,     // async reset, low
    input wire logic        psel,        // apb select
    input wire logic        penable,     // apb access phase
    input wire logic        pwrite,      // apb direction
    input wire logic        pready,      // apb ready
    input wire logic [31:0] prdata,      // apb read data
    input wire logic        pslverr,     // apb error
    input wire logic [15:0] cpu_pc,      // core program counter
    input wire logic [7:0]  cpu_ps,      // core status
    input wire logic        stack_push,  // push strobe
    input wire logic [7:0]  stack_data,  // pushed byte
    input wire logic        vector_load, // pc load strobe
    input wire logic [15:0] vector_addr, // vector low address
    input wire logic        irq_flag,    // disable flag
    input wire logic        accept_busy  // accept running
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    zero_wait_a: assert property (psel && penable |-> pready)
        else $error("apb slave inserted a wait");
    push_count_a: assert property ($rose(stack_push) |-> stack_push [*3] ##1 !stack_push)
        else $error("push burst is not three bytes");
    push_data_a: assert property ($rose(stack_push) |-> stack_data == cpu_pc[15:8]
        ##1 stack_data == cpu_pc[7:0] ##1 stack_data == cpu_ps)
        else $error("pushed bytes out of order");
    flag_on_accept_a: assert property ($rose(stack_push) |-> irq_flag)
        else $error("disable flag not set on accept");
    busy_on_push_a: assert property (stack_push |-> accept_busy)
        else $error("push outside accept sequence");
    vector_after_push_a: assert property ($fell(stack_push) |-> ##1 vector_load)
        else $error("vector fetch does not follow pushes");
    vector_single_a: assert property (vector_load |=> !vector_load)
        else $error("vector load longer than one cycle");
    vector_range_a: assert property (vector_load |-> !vector_addr[0] && vector_addr >= 16'hffdc)
        else $error("vector address outside table");
    unmapped_zero_a: assert property (psel && penable && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read returned data");

    cover property (vector_load && vector_addr == 16'hffdc);
    cover property (psel && penable && pslverr);
    cover property ($rose(stack_push));
endmodule
bind vectored_interrupt_controller vic_props
#(
    .key_width(key_width), .se0_count(se0_count), .idle_count(idle_count)
) props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .cpu_pc(cpu_pc), .cpu_ps(cpu_ps),
    .stack_push(stack_push), .stack_data(stack_data), .vector_load(vector_load),
    .vector_addr(vector_addr), .irq_flag(irq_flag), .accept_busy(accept_busy)
);
`default_nettype wire

// ### dv/core_model.sv
// behavioural processor core that takes vectors and logs stack pushes
`timescale 1ns/1ps
`default_nettype none
module core_model
(
    input  wire logic        pclk,         // system clock
    input  wire logic        presetn,      // async reset, low
    input  wire logic        stack_push,   // push strobe
    input  wire logic [7:0]  stack_data,   // pushed byte
    input  wire logic        vector_load,  // pc load strobe
    input  wire logic [15:0] vector_addr,  // vector low address
    output var  logic        cpu_ready,    // core can be interrupted
    output logic      [15:0] cpu_pc,       // fixed program counter
    output logic      [7:0]  cpu_ps,       // fixed status byte
    output logic             cpu_clr_flag  // handler re-enables
);
    logic [15:0] vq[$];
    logic [7:0]  pq[$];
    logic [1:0]  cli_q;

    // constant pc and status make every pushed byte predictable
    assign cpu_pc = 16'h1234;
    assign cpu_ps = 8'h5a;
    assign cpu_clr_flag = cli_q[1];

    // the handler clears the flag two cycles after each vector fetch
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cli_q <= 2'h0;
            cpu_ready <= 1'b0;
        end
        else
        begin
            cpu_ready <= 1'b1;
            cli_q <= {cli_q[0], vector_load};
            if (stack_push)
                pq.push_back(stack_data);
            if (vector_load)
                vq.push_back(vector_addr);
        end
    end
endmodule
`default_nettype wire

// ### dv/vectored_interrupt_controller_test.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("[ERR] %s exp %h got %h", n, e, g); \
        end \
    end
module vectored_interrupt_controller_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_set_flag = 1'b0;
    logic [11:0] paddr = 12'h0, ev = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, stack_push, vector_load, irq_flag, accept_busy, rerr;
    logic [7:0]  stack_data, cpu_ps, keys = 8'hff;
    logic [15:0] vector_addr, cpu_pc;
    logic        cpu_ready, cpu_clr_flag;
    logic        se0 = 1'b0, pin_a = 1'b0, pin_b = 1'b0, cntr = 1'b0, idle = 1'b0;
    int          miscompares = 0, cmp_count = 0;
    localparam logic [11:0] rq1 = vic_pkg::req_one_idx << 2, rq2 = vic_pkg::req_two_idx << 2;
    localparam logic [11:0] en1 = vic_pkg::enable_one_idx << 2, en2 = vic_pkg::enable_two_idx << 2;

    always #2 pclk = ~pclk;

    vectored_interrupt_controller #(.key_width(8), .se0_count(4), .idle_count(20)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .usb_se0(se0), .usb_idle(idle), .usb_resume(ev[0]), .usb_sof(ev[1]),
        .usb_xact_done(ev[2]), .ext_bus_done(ev[3]), .ext_pin_irq_a(pin_a),
        .ext_pin_irq_b(pin_b), .counter_pin(cntr), .timer_x_uflow(ev[4]),
        .timer_1_uflow(ev[5]), .timer_2_uflow(ev[6]), .hub_port_change(ev[7]),
        .ser_rx_done(ev[8]), .ser_tx_done(ev[9]), .adc_done(ev[10]), .key_port(keys),
        .soft_break_instruction(ev[11]), .cpu_ready(cpu_ready), .cpu_pc(cpu_pc),
        .cpu_ps(cpu_ps), .cpu_set_flag(cpu_set_flag), .cpu_clr_flag(cpu_clr_flag),
        .stack_push(stack_push), .stack_data(stack_data), .vector_load(vector_load),
        .vector_addr(vector_addr), .irq_flag(irq_flag), .accept_busy(accept_busy));

    core_model core (.pclk(pclk), .presetn(presetn), .stack_push(stack_push),
        .stack_data(stack_data), .vector_load(vector_load), .vector_addr(vector_addr),
        .cpu_ready(cpu_ready), .cpu_pc(cpu_pc), .cpu_ps(cpu_ps), .cpu_clr_flag(cpu_clr_flag));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never re-drives psel in this time step
        @(posedge pclk);
    endtask

    task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(n, e, rdat[7:0])
    endtask

    task automatic pulse(input logic [11:0] m);
        ev <= m;
        @(posedge pclk);
        ev <= 12'h0;
        @(posedge pclk);
    endtask

    task automatic set_flag;
        cpu_set_flag <= 1'b1;
        @(posedge pclk);
        cpu_set_flag <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        `CHK("reset vector", 16'hfffc, core.vq[0])
        $display("test reset done");
        apb(1'b1, en1, 32'ha5);
        apb(1'b1, en2, 32'h5a);
        rd("enable one", en1, 8'ha5);
        rd("enable two", en2, 8'h5a);
        apb(1'b1, en1, 32'h0);
        apb(1'b1, en2, 32'h0);
        rd("enable clear", en1, 8'h00);
        rd("unmapped", 12'h200, 8'h00);
        `CHK("unmapped error", 1'b1, rerr)
        $display("test registers done");
        pulse(12'h010);
        rd("timer x pending", rq1, 8'h20);
        apb(1'b1, rq1, 32'hff);
        rd("write one keeps", rq1, 8'h20);
        apb(1'b1, rq1, 32'h0);
        rd("write zero clears", rq1, 8'h00);
        $display("test request bits done");
        apb(1'b1, en1, 32'h20);
        set_flag;
        pulse(12'h010);
        repeat (10) @(posedge pclk);
        `CHK("flag blocks", 1, core.vq.size())
        rd("still pending", rq1, 8'h20);
        pulse(12'h800);
        repeat (30) @(posedge pclk);
        `CHK("break vector", 16'hffdc, core.vq[1])
        `CHK("timer x vector", 16'hfff0, core.vq[2])
        `CHK("push pc high", 8'h12, core.pq[0])
        `CHK("push pc low", 8'h34, core.pq[1])
        `CHK("push status", 8'h5a, core.pq[2])
        rd("served cleared", rq1, 8'h00);
        $display("test flag and break done");
        set_flag;
        apb(1'b1, en1, 32'hff);
        apb(1'b1, en2, 32'hff);
        se0 <= 1'b1;
        repeat (6) @(posedge pclk);
        se0 <= 1'b0;
        pin_a <= 1'b1;
        pin_b <= 1'b1;
        cntr <= 1'b1;
        keys <= 8'hfe;
        pulse(12'h7ff);
        repeat (3) @(posedge pclk);
        rd("all low sources", rq1, 8'hff);
        rd("all high sources", rq2, 8'h7f);
        pulse(12'h800);
        repeat (200) @(posedge pclk);
        `CHK("vector count", 19, core.vq.size())
        for (int i = 0; i < 15; i++)
            `CHK("priority vector", 16'hfffa - 16'(2 * i), core.vq[4 + i])
        rd("low drained", rq1, 8'h00);
        $display("test priority done");
        set_flag;
        apb(1'b1, vic_pkg::edge_sel_idx << 2, 32'h4);
        cntr <= 1'b0;
        idle <= 1'b1;
        repeat (24) @(posedge pclk);
        idle <= 1'b0;
        rd("falling edge", rq2, 8'h10);
        rd("suspend idle", rq1, 8'h04);
        rd("status code", vic_pkg::status_idx << 2, 8'h0e);
        pin_a <= 1'b0;
        apb(1'b1, vic_pkg::edge_sel_idx << 2, 32'h5);
        rd("select change", rq1, 8'h14);
        $display("test edges done");
        finish_test;
    end

    initial
    begin
        repeat (3000) @(posedge pclk);
        miscompares++;
        finish_test;
    end
endmodule
`default_nettype wire
